// file: fet_timing_map.svh
// Purpose: Named constants for the FET channel fault timing block
// Assumes: 50 MHz system clock, Avalon-MM word addressing of 32-bit registers
// Notes:   Times are kept in microseconds; cycle counts derive from the clock rate
`ifndef FET_TIMING_MAP_SVH
`define FET_TIMING_MAP_SVH

`define CLK_MHZ          50
`define US_TO_CYC(us)    ((us) * `CLK_MHZ)
// On-state blank times, us
`define ON_BLANK_US_3    56
`define ON_BLANK_US_2    28
`define ON_BLANK_US_1    14
`define ON_BLANK_US_0    5
// Off-state blank times, us
`define OFF_BLANK_US_3   4000
`define OFF_BLANK_US_2   280
`define OFF_BLANK_US_1   140
`define OFF_BLANK_US_0   80
// Retry periods, us
`define RETRY_LONG_US    55000
`define RETRY_SHORT_US   10000
// Fault filter time, us
`define FILTER_US        2
// Short-to-battery reference levels, percent of regulator
`define STB_PCT_7        7'h1f
`define STB_PCT_6        7'h12
`define STB_PCT_5        7'h10
`define STB_PCT_4        7'h0e
`define STB_PCT_3        7'h0c
`define STB_PCT_2        7'h0a
`define STB_PCT_1        7'h08
`define STB_PCT_0        7'h06
// Short-to-ground reference levels, percent of regulator
`define STG_PCT_HI       7'h42
`define STG_PCT_LO       7'h2d
// Register word addresses
`define ADDR_CTRL        4'h0
`define ADDR_CFG         4'h1
`define ADDR_STATUS      4'h2
`define ADDR_MASK        4'h3
`define ADDR_IRQ         4'h4
`define ADDR_REF         4'h5
// Config register fields
`define CFG_ON_LSB       0
`define CFG_OFF_LSB      2
`define CFG_STB_LSB      4
`define CFG_STG_BIT      7
`define CFG_NPD_BIT      8
`define CFG_RETRY_BIT    9
`define CFG_RST          10'h000
`define TIMER_W          22

`endif

// file: fet_timing_pkg.sv
// Purpose: Types for the FET channel fault timing block
// Assumes: Constants come from fet_timing_map.svh
// Notes:   Configuration travels as one packed struct
package fet_timing_pkg;
  typedef struct packed {
    logic       retry_period_sel;
    logic       pulldown_current_disable;
    logic       stg_threshold_sel;
    logic [2:0] stb_threshold_sel;
    logic [1:0] off_blank_sel;
    logic [1:0] on_blank_sel;
  } chan_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BLANK = 2'b01,
    ST_WATCH = 2'b10
  } blank_state_t;
endpackage

// file: fet_channel_fault_timing.sv
// Purpose: One channel's gate control, fault blanking, fault latching and shared retry
// Assumes: Drain comparator results arrive asynchronously and are synchronised here
// Notes:   Thresholds are exported as percent codes for the analog reference DAC
// Overview of operation
// RQ1 - Gate high: on-blank field picks 56, 28, 14 or 5 us
// RQ2 - Gate low: off-blank field picks 4000, 280, 140 or 80 us
// RQ3 - Three-bit field picks battery-short level 31,18,16,14,12,10,8,6 percent
// RQ4 - Off state: one bit picks ground-short level 66 or 45 percent
// RQ5 - Pull-down current on only while gate low and disable bit clear
// RQ6 - Retry period bit picks about 55 ms or about 10 ms
// RQ7 - Gate high needs reset released, no battery fault, input or serial bit
// RQ8 - A detected battery short pulls the gate low at once
// RQ9 - Faults stay latched, clear only at blank end when gone; the battery fault here clears when the retry timer expires
// RQ10 - One shared retry timer re-attempts drive after battery shorts
// RQ11 - Timers count the system clock; blank restarts on each gate edge
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "fet_timing_map.svh"

module fet_channel_fault_timing
  import fet_timing_pkg::*;
#(
  parameter int RETRY_LONG_CYC  = `US_TO_CYC(`RETRY_LONG_US),
  parameter int RETRY_SHORT_CYC = `US_TO_CYC(`RETRY_SHORT_US)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        chip_reset_low,
  input  wire logic        direct_input,
  input  wire logic        drain_sense,
  input  wire logic        stg_sense,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             gate_output,
  output logic             pulldown_enable,
  output logic      [6:0]  stb_ref_pct,
  output logic      [6:0]  stg_ref_pct,
  output logic             irq
);

  localparam int TW = `TIMER_W;
  localparam int FILT_CYC = `US_TO_CYC(`FILTER_US);

  // Blank length in cycles for the present gate level
  function automatic logic [TW-1:0] blank_cyc(input logic on, input logic [1:0] sel);
    logic [TW-1:0] r;
    r = '0;
    if (on) begin
      case (sel)
        2'b11:   r = TW'(`US_TO_CYC(`ON_BLANK_US_3)); // RQ1
        2'b10:   r = TW'(`US_TO_CYC(`ON_BLANK_US_2));
        2'b01:   r = TW'(`US_TO_CYC(`ON_BLANK_US_1));
        default: r = TW'(`US_TO_CYC(`ON_BLANK_US_0));
      endcase
    end else begin
      case (sel)
        2'b11:   r = TW'(`US_TO_CYC(`OFF_BLANK_US_3)); // RQ2
        2'b10:   r = TW'(`US_TO_CYC(`OFF_BLANK_US_2));
        2'b01:   r = TW'(`US_TO_CYC(`OFF_BLANK_US_1));
        default: r = TW'(`US_TO_CYC(`OFF_BLANK_US_0));
      endcase
    end
    return r;
  endfunction

  // Pin synchronisers: first stage read only by the second
  logic [3:0] sync1_q, sync2_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {chip_reset_low, direct_input, drain_sense, stg_sense};
      sync2_q <= sync1_q;
    end
  end
  logic rst_pin_n, in_s, drn_s, stg_s;
  assign {rst_pin_n, in_s, drn_s, stg_s} = sync2_q;

  // Register state
  logic       serial_gate_bit_q, serial_gate_bit_d;
  chan_cfg_t  cfg_q, cfg_d;
  logic [1:0] sts_q, sts_d;       // [0] battery short, [1] ground short
  logic [1:0] mask_q, mask_d;
  logic       rd_pend_q, rd_pend_d;
  logic [31:0] rdata_q, rdata_d;

  // Fault engine state
  blank_state_t    bst_q, bst_d;
  logic [TW-1:0]   bcnt_q, bcnt_d;
  // Filter counter must reach the full filter time, so it is sized for it
  logic [6:0]      fcnt_q, fcnt_d;
  logic            stb_flt_q, stb_flt_d;
  logic            stg_flt_q, stg_flt_d;
  logic [TW-1:0]   rcnt_q, rcnt_d;
  logic            gate_q, gate_d;
  logic            retry_hold_q, retry_hold_d;

  logic req_on, stb_evt, stg_evt, blank_end;
  assign req_on    = in_s | serial_gate_bit_q;
  assign blank_end = (bst_q == ST_BLANK) && (bcnt_q == '0);

  // Gate, blanking, filtering and fault latching
  always_comb begin
    gate_d       = rst_pin_n & ~stb_flt_q & ~retry_hold_q & req_on; // RQ7
    bst_d        = bst_q;
    bcnt_d       = bcnt_q;
    fcnt_d       = fcnt_q;
    stb_flt_d    = stb_flt_q;
    stg_flt_d    = stg_flt_q;
    rcnt_d       = rcnt_q;
    retry_hold_d = retry_hold_q;
    stb_evt      = 1'b0;
    stg_evt      = 1'b0;
    if (gate_d != gate_q) begin
      bst_d  = ST_BLANK; // RQ11
      bcnt_d = blank_cyc(gate_d, gate_d ? cfg_q.on_blank_sel : cfg_q.off_blank_sel);
      fcnt_d = '0;
    end else begin
      case (bst_q)
        ST_IDLE:  bst_d = ST_IDLE;
        ST_BLANK: begin
          if (bcnt_q != '0) begin
            bcnt_d = bcnt_q - 1'b1;
          end else begin
            bst_d = ST_WATCH;
            // Clearance here when the fault is seen gone; the battery fault also clears at retry end
            if (gate_q && !drn_s)  stb_flt_d = 1'b0; // RQ9
            if (!gate_q && !stg_s) stg_flt_d = 1'b0; // RQ9
          end
        end
        ST_WATCH: begin
          // Filter rejects short glitches on the comparator
          if ((gate_q ? drn_s : stg_s) && !mask_q[gate_q ? 0 : 1]) begin
            if (fcnt_q == 7'(FILT_CYC - 1)) begin
              fcnt_d = '0;
              if (gate_q) begin
                stb_flt_d = 1'b1;
                stb_evt   = 1'b1;
              end else begin
                stg_flt_d = 1'b1;
                stg_evt   = 1'b1;
              end
            end else begin
              fcnt_d = fcnt_q + 1'b1;
            end
          end else begin
            fcnt_d = '0;
          end
        end
        default: bst_d = ST_IDLE;
      endcase
    end
    if (stb_evt) begin
      gate_d       = 1'b0; // RQ8
      // A fault turn-off is a gate edge too; off-state blanking restarts here
      bst_d        = ST_BLANK; // RQ11
      bcnt_d       = blank_cyc(1'b0, cfg_q.off_blank_sel);
      fcnt_d       = '0;
      retry_hold_d = 1'b1;
      rcnt_d       = cfg_q.retry_period_sel ? TW'(RETRY_LONG_CYC) : TW'(RETRY_SHORT_CYC); // RQ6
    end else if (retry_hold_q) begin
      // Shared retry timer re-arms drive and releases the battery fault latch
      if (rcnt_q != '0) begin
        rcnt_d = rcnt_q - 1'b1;
      end else begin
        retry_hold_d = 1'b0; // RQ10
        stb_flt_d    = 1'b0;
      end
    end
    if (!rst_pin_n) begin
      stb_flt_d    = 1'b0;
      stg_flt_d    = 1'b0;
      retry_hold_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bst_q        <= ST_IDLE;
      bcnt_q       <= '0;
      fcnt_q       <= 7'h00;
      stb_flt_q    <= 1'b0;
      stg_flt_q    <= 1'b0;
      rcnt_q       <= '0;
      gate_q       <= 1'b0;
      retry_hold_q <= 1'b0;
    end else begin
      bst_q        <= bst_d;
      bcnt_q       <= bcnt_d;
      fcnt_q       <= fcnt_d;
      stb_flt_q    <= stb_flt_d;
      stg_flt_q    <= stg_flt_d;
      rcnt_q       <= rcnt_d;
      gate_q       <= gate_d;
      retry_hold_q <= retry_hold_d;
    end
  end

  // Outputs from flops; thresholds decoded from configuration
  assign gate_output     = gate_q;
  assign pulldown_enable = ~gate_q & ~cfg_q.pulldown_current_disable; // RQ5
  always_comb begin
    case (cfg_q.stb_threshold_sel) // RQ3
      3'b111:  stb_ref_pct = `STB_PCT_7;
      3'b110:  stb_ref_pct = `STB_PCT_6;
      3'b101:  stb_ref_pct = `STB_PCT_5;
      3'b100:  stb_ref_pct = `STB_PCT_4;
      3'b011:  stb_ref_pct = `STB_PCT_3;
      3'b010:  stb_ref_pct = `STB_PCT_2;
      3'b001:  stb_ref_pct = `STB_PCT_1;
      default: stb_ref_pct = `STB_PCT_0;
    endcase
    stg_ref_pct = cfg_q.stg_threshold_sel ? `STG_PCT_HI : `STG_PCT_LO; // RQ4
  end

  // Avalon slave: writes take one cycle, reads answer on the second cycle
  logic wr_ctrl, wr_cfg, wr_mask, wr_irq;
  always_comb begin
    wr_ctrl = avs_write && avs_address == `ADDR_CTRL;
    wr_cfg  = avs_write && avs_address == `ADDR_CFG;
    wr_mask = avs_write && avs_address == `ADDR_MASK;
    wr_irq  = avs_write && avs_address == `ADDR_IRQ;
    serial_gate_bit_d = wr_ctrl ? avs_writedata[0] : serial_gate_bit_q;
    cfg_d   = wr_cfg ? chan_cfg_t'(avs_writedata[9:0]) : cfg_q;
    mask_d  = wr_mask ? avs_writedata[1:0] : mask_q;
    // Set beats clear so a fault in the clearing cycle is kept
    sts_d   = (sts_q & ~(wr_irq ? avs_writedata[1:0] : 2'b00)) | {stg_evt, stb_evt};
    rd_pend_d = avs_read && !rd_pend_q;
    rdata_d = 32'h0;
    case (avs_address)
      `ADDR_CTRL:   rdata_d = {31'h0, serial_gate_bit_q};
      `ADDR_CFG:    rdata_d = {22'h0, cfg_q};
      `ADDR_STATUS: rdata_d = {28'h0, retry_hold_q, gate_q, stg_flt_q, stb_flt_q};
      `ADDR_MASK:   rdata_d = {30'h0, mask_q};
      `ADDR_IRQ:    rdata_d = {30'h0, sts_q};
      `ADDR_REF:    rdata_d = {18'h0, stg_ref_pct, stb_ref_pct};
      default:      rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_gate_bit_q <= 1'b0;
      cfg_q             <= chan_cfg_t'(`CFG_RST);
      mask_q            <= 2'b00;
      sts_q             <= 2'b00;
      rd_pend_q         <= 1'b0;
      rdata_q           <= 32'h0;
    end else begin
      serial_gate_bit_q <= serial_gate_bit_d;
      cfg_q             <= cfg_d;
      mask_q            <= mask_d;
      sts_q             <= sts_d;
      rd_pend_q         <= rd_pend_d;
      rdata_q           <= rdata_d;
    end
  end

  assign avs_waitrequest = avs_read && !rd_pend_q;
  assign avs_readdata    = rdata_q;
  assign irq             = |(sts_q & ~mask_q);

  // Checks
  AST_GATE_NEEDS_REQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gate_output |-> $past(req_on) && $past(rst_pin_n)) else $error("gate high without request"); // RQ7
  AST_STB_KILLS_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stb_evt |=> !gate_output) else $error("gate stayed high after battery short"); // RQ8
  AST_PD_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pulldown_enable |-> !gate_output && !cfg_q.pulldown_current_disable) else $error("pulldown wrong"); // RQ5
  AST_BLANK_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (gate_q != $past(gate_q)) |-> bst_q == ST_BLANK) else $error("blank not restarted"); // RQ11
  AST_ON_BLANK_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(gate_q) && cfg_q.on_blank_sel == 2'b00 |-> bcnt_q == 22'd250) else $error("on blank length"); // RQ1
  AST_OFF_BLANK_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(gate_q) && cfg_q.off_blank_sel == 2'b00 |-> bcnt_q == 22'd4000) else $error("off blank length"); // RQ2
  AST_STB_REF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_q.stb_threshold_sel == 3'b111 |-> stb_ref_pct == 7'h1f) else $error("stb ref"); // RQ3
  AST_STG_REF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg_q.stg_threshold_sel |-> stg_ref_pct == 7'h2d) else $error("stg ref"); // RQ4
  AST_FAULT_HELD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(stg_flt_q) |-> $past(blank_end) || !$past(rst_pin_n)) else $error("fault cleared early"); // RQ9
  AST_RETRY_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stb_evt && !cfg_q.retry_period_sel |=> rcnt_q == TW'(RETRY_SHORT_CYC)) else $error("retry load"); // RQ6 RQ10

  // Further checks on pulldown, gate blocking, blank restart and reference decode
  AST_PD_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_output && !cfg_q.pulldown_current_disable |-> pulldown_enable) else $error("pulldown missing"); // RQ5
  AST_STB_REF_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_q.stb_threshold_sel == 3'b000 |-> stb_ref_pct == 7'h06) else $error("stb ref low"); // RQ3
  AST_STG_REF_HI: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_q.stg_threshold_sel |-> stg_ref_pct == 7'h42) else $error("stg ref high"); // RQ4
  AST_RETRY_BLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    retry_hold_q |=> !gate_output) else $error("gate high during retry wait"); // RQ10
  AST_STB_FALL_BLANK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stb_evt |=> bst_q == ST_BLANK) else $error("no blank after fault turn-off"); // RQ11
  AST_FAULT_BLOCKS_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stb_flt_q |=> !gate_output) else $error("gate high with battery fault"); // RQ7
  AST_PIN_RESET_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rst_pin_n |=> !gate_output) else $error("gate high in chip reset"); // RQ7

endmodule // fet_channel_fault_timing

// file: fet_load_model.sv
// Purpose: External low-side FET and load as seen at the drain
// Assumes: The bench commands battery and ground shorts
// Notes:   Comparators are always driven; one flop for settling
`timescale 1ns/10ps
module fet_load_model (
  input  wire logic clk_sys,
  input  wire logic gate_output,
  input  wire logic stb_short,
  input  wire logic stg_short,
  output logic      drain_sense,
  output logic      stg_sense
);
  // A battery short only shows while the FET conducts, a ground short only while off
  always_ff @(posedge clk_sys) begin
    drain_sense <= gate_output & stb_short;
    stg_sense   <= ~gate_output & stg_short;
  end
endmodule // fet_load_model

// file: tb_fet_channel_fault_timing.sv
// Purpose: Self-checking bench for the channel fault timing block
// Assumes: Retry counts shortened to 1000 and 2000 cycles
// Notes:   Expected times come from integer tables, not from the design
`timescale 1ns/10ps
module tb_fet_channel_fault_timing;
  logic        clk_sys, rst_n, chip_reset_low, direct_input;
  logic        stb_short, stg_short, drain_sense, stg_sense;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        gate_output, pulldown_enable, irq;
  logic [6:0]  stb_ref_pct, stg_ref_pct;
  int          n_mismatch, tests_run, n, k, bl;
  int          on_us[4]   = '{5, 14, 28, 56};
  int          off_us[3]  = '{80, 140, 280};
  int          stb_pct[8] = '{6, 8, 10, 12, 14, 16, 18, 31};

  fet_channel_fault_timing #(.RETRY_LONG_CYC(2000), .RETRY_SHORT_CYC(1000)) u_fet_channel_fault_timing (
    .clk_sys(clk_sys), .rst_n(rst_n), .chip_reset_low(chip_reset_low),
    .direct_input(direct_input), .drain_sense(drain_sense), .stg_sense(stg_sense),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gate_output(gate_output), .pulldown_enable(pulldown_enable), .stb_ref_pct(stb_ref_pct),
    .stg_ref_pct(stg_ref_pct), .irq(irq));

  fet_load_model u_fet_load_model (
    .clk_sys(clk_sys), .gate_output(gate_output), .stb_short(stb_short),
    .stg_short(stg_short), .drain_sense(drain_sense), .stg_sense(stg_sense));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // Timing windows allow a few cycles of synchroniser and register delay
  task automatic win(input int got, input int lo, input string m);
    tests_run++;
    if (got < lo || got > lo + 12) begin
      n_mismatch++;
      $display("unexpected at %0t: %s took %0d want %0d", $time, m, got, lo);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Counts edges until gate or irq shows the level; bounded
  task automatic wgate(input logic sel, input logic v);
    n = 0;
    while (((sel ? irq : gate_output) !== v) && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Watchdog sized above the sum of all blank and retry waits
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end

  initial begin
    {rst_n, direct_input, stb_short, stg_short, avs_read, avs_write} = 6'h0;
    chip_reset_low = 1'b1;
    avs_address    = 4'h0;
    avs_writedata  = 32'h0;
    n_mismatch     = 0;
    tests_run      = 0;
    k = $urandom(32'h367bcd61);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(stb_ref_pct, 6, "stb ref");
    chk(stg_ref_pct, 45, "stg ref");
    chk(pulldown_enable, 1, "pulldown");
    chk({gate_output, irq}, 0, "gate irq");
    bus(0, 4'h1, 0);
    chk(rd, 0, "cfg reset");
    bus(0, 4'hf, 0);
    chk(rd, 0, "unmapped");
    $display("test reset done");
    // Every threshold code, with a random retry bit alongside
    for (int i = 0; i < 8; i++) begin
      k = $urandom;
      bus(1, 4'h1, {22'h0, k[0], 1'b0, i[0], i[2:0], 4'h0});
      chk(stb_ref_pct, stb_pct[i], "stb ref");
      chk(stg_ref_pct, i[0] ? 66 : 45, "stg ref");
      bus(0, 4'h5, 0);
      chk(rd, {i[0] ? 7'h42 : 7'h2d, 7'(stb_pct[i])}, "ref reg");
    end
    $display("test thresholds done");
    bus(1, 4'h1, 32'h0);
    direct_input <= 1'b1;
    wgate(0, 1);
    chk(pulldown_enable, 0, "pd gate on");
    bus(1, 4'h0, 32'h1);
    direct_input <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(gate_output, 1, "serial gate");
    chip_reset_low <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(gate_output, 0, "chip reset");
    chip_reset_low <= 1'b1;
    bus(1, 4'h0, 32'h0);
    repeat (6) @(posedge clk_sys);
    chk(pulldown_enable, 1, "pd gate off");
    bus(1, 4'h1, 32'h100);
    chk(pulldown_enable, 0, "pd disabled");
    $display("test gate done");
    // Battery short under each on-blank code; last pass uses the long retry
    for (int c = 0; c < 5; c++) begin
      bl = on_us[c % 4] * 50;
      bus(1, 4'h1, (c == 4) ? 32'h200 : 32'(c % 4));
      stb_short    <= 1'b1;
      direct_input <= 1'b1;
      wgate(0, 1);
      wgate(0, 0);
      win(n, bl + 100, "on blank");
      bus(0, 4'h2, 0);
      chk(rd[0], 1, "stb latched");
      chk(irq, 1, "irq stb");
      stb_short <= 1'b0;
      wgate(0, 1);
      win(n, (c == 4) ? 1996 : 996, "retry");
      repeat (bl + 20) @(posedge clk_sys);
      bus(0, 4'h2, 0);
      chk(rd[0], 0, "stb cleared");
      bus(1, 4'h4, 32'h3);
      chk(irq, 0, "irq w1c");
      direct_input <= 1'b0;
      wgate(0, 0);
    end
    $display("test on blank done");
    // Ground short under each off-blank code short of the longest
    for (int c = 0; c < 3; c++) begin
      bl = off_us[c] * 50;
      bus(1, 4'h1, 32'(c) << 2);
      direct_input <= 1'b1;
      wgate(0, 1);
      stg_short    <= 1'b1;
      direct_input <= 1'b0;
      wgate(0, 0);
      wgate(1, 1);
      win(n, bl + 100, "off blank");
      stg_short <= 1'b0;
      bus(0, 4'h2, 0);
      chk(rd[1], 1, "stg latched");
      bus(1, 4'h4, 32'h3);
      chk(irq, 0, "irq w1c");
      direct_input <= 1'b1;
      wgate(0, 1);
      direct_input <= 1'b0;
      wgate(0, 0);
      repeat (bl + 150) @(posedge clk_sys);
      bus(0, 4'h2, 0);
      chk(rd[1], 0, "stg cleared");
    end
    $display("test off blank done");
    // A masked channel keeps driving through a battery short
    bus(1, 4'h1, 32'h0);
    bus(1, 4'h3, 32'h1);
    stb_short    <= 1'b1;
    direct_input <= 1'b1;
    wgate(0, 1);
    repeat (500) @(posedge clk_sys);
    chk({gate_output, irq}, 2'b10, "masked");
    $display("test mask done");
    conclude();
  end
endmodule // tb_fet_channel_fault_timing
